// [frc_pkg.sv]
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package frc_pkg;
  localparam logic [7:0] CMD_WRITE_FUNCTION = 8'h42;
  localparam logic [7:0] CMD_PARAMS_PERSISTENT = 8'h65;
  localparam logic [7:0] CMD_PARAMS_WORKING_A = 8'hC0;
  localparam logic [7:0] CMD_PARAMS_WORKING_B = 8'h63;
  localparam int FN_RST_DIS = 0;
  localparam int FN_SIDE = 1;
  localparam int FN_PROGRAM_SUSPENDED_FLAG = 2;
  localparam int FN_ERASE_SUSPENDED_FLAG = 3;
  localparam int FN_LOCK_LO = 4;
  localparam logic [7:0] FN_OTP_MASK = 8'hF3;
  localparam logic [7:0] PARAM_RESET = 8'h00;
  localparam int RP_PIN_SEL = 7;
  localparam int RP_DUMMY_HI = 6;
  localparam int RP_DUMMY_LO = 3;
  localparam int RP_WRAP = 2;
  localparam int BLOCK_W = 9;
  localparam logic [BLOCK_W-1:0] BLOCK_LAST = 9'h1FF;
  localparam logic [1:0] UP_WAIT = 2'h2;
endpackage : frc_pkg

// [frc_regs.sv]
`timescale 1ns/100ps
module frc_regs #(
  parameter logic [3:0] DEFAULT_DUMMY = 4'h8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic link_nrst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_data,
  input wire logic strap_rst_dis,
  input wire logic suspend_pgm,
  input wire logic suspend_ers,
  input wire logic resume,
  input wire logic quad_lines_enable,
  input wire logic four_wire_command_mode,
  input wire logic [3:0] protect_level,
  input wire logic [frc_pkg::BLOCK_W-1:0] target_block,
  input wire logic [1:0] target_row,
  input wire logic row_program_req,
  output logic [7:0] function_config_status,
  output logic [7:0] read_parameters,
  output logic [7:0] read_parameters_nv,
  output logic pin_is_reset,
  output logic [3:0] dummy_cycles,
  output logic [6:0] burst_bytes,
  output logic wrap_in_burst,
  output logic block_protected,
  output logic row_program_refused
);
  localparam int BLOCK_W_P = frc_pkg::BLOCK_W;

  //////////////////////////////////////////////////////////////////////////////
  // link domain: capture command, toggle event
  logic [7:0] l_code_q;
  logic [7:0] l_data_q;
  logic l_tog_q;
  always_ff @(posedge link_clk) begin
    if (!link_nrst) begin
      l_code_q <= 8'h00;
      l_data_q <= 8'h00;
      l_tog_q <= 1'b0;
    end else if (cmd_valid) begin
      l_code_q <= cmd_code;
      l_data_q <= cmd_data;
      l_tog_q <= ~l_tog_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // power-up sequence: wait for pin synchronisers, then strap catch and copy load
  logic [1:0] up_cnt_q;
  logic up_done_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      up_cnt_q <= 2'h0;
    end else if (up_cnt_q != frc_pkg::UP_WAIT) begin
      up_cnt_q <= 2'(up_cnt_q + 2'h1);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      up_done_q <= 1'b0;
    end else begin
      up_done_q <= (up_cnt_q == frc_pkg::UP_WAIT);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // crossing into clk domain
  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_s3_q;
  logic [7:0] code_q;
  logic [7:0] data_q;
  logic cmd_go_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
      code_q <= 8'h00;
      data_q <= 8'h00;
      cmd_go_q <= 1'b0;
    end else begin
      tog_s1_q <= l_tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
      cmd_go_q <= (tog_s2_q ^ tog_s3_q) && up_done_q;
      if (tog_s2_q ^ tog_s3_q) begin
        code_q <= l_code_q;
        data_q <= l_data_q;
      end
    end
  end

  // pin inputs synchronised
  logic [13:0] pin_s1_q;
  logic [13:0] pin_s2_q;
  logic [BLOCK_W_P-1:0] blk_s1_q;
  logic [BLOCK_W_P-1:0] blk_s2_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_s1_q <= 14'h0000;
      pin_s2_q <= 14'h0000;
      blk_s1_q <= '0;
      blk_s2_q <= '0;
    end else begin
      pin_s1_q <= {strap_rst_dis, suspend_pgm, suspend_ers, resume, quad_lines_enable,
                   four_wire_command_mode, protect_level, target_row, row_program_req, 1'b0};
      pin_s2_q <= pin_s1_q;
      blk_s1_q <= target_block;
      blk_s2_q <= blk_s1_q;
    end
  end
  logic s_strap;
  logic s_sus_pgm;
  logic s_sus_ers;
  logic s_resume;
  logic s_quad;
  logic s_qpi;
  logic [3:0] s_level;
  logic [1:0] s_row;
  logic s_row_req;
  assign {s_strap, s_sus_pgm, s_sus_ers, s_resume, s_quad, s_qpi, s_level, s_row, s_row_req}
    = pin_s2_q[13:1];

  //////////////////////////////////////////////////////////////////////////////
  // function register
  function automatic logic cmd_is(input logic go, input logic [7:0] code,
                                  input logic [7:0] want);
    cmd_is = go && (code == want);
  endfunction : cmd_is

  logic rst_dis_q;
  logic side_q;
  logic program_suspended_flag_q;
  logic erase_suspended_flag_q;
  logic [3:0] lock_q;
  logic [7:0] fn_word;
  logic fn_wr;
  assign fn_wr = cmd_is(cmd_go_q, code_q, frc_pkg::CMD_WRITE_FUNCTION);
  assign fn_word = {lock_q, erase_suspended_flag_q, program_suspended_flag_q, side_q, rst_dis_q};

  // reset disable: strap at power-up, then only 0 to 1
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rst_dis_q <= 1'b0;
    end else if (!up_done_q) begin
      rst_dis_q <= s_strap;
    end else if (fn_wr) begin
      rst_dis_q <= rst_dis_q | data_q[frc_pkg::FN_RST_DIS];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      side_q <= 1'b0;
    end else if (fn_wr) begin
      side_q <= side_q | data_q[frc_pkg::FN_SIDE];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lock_q <= 4'h0;
    end else if (fn_wr) begin
      lock_q <= lock_q | data_q[frc_pkg::FN_LOCK_LO +: 4];
    end
  end

  // flags ignore host data; suspend wins over resume
  always_ff @(posedge clk) begin
    if (!nrst) begin
      program_suspended_flag_q <= 1'b0;
    end else if (s_sus_pgm) begin
      program_suspended_flag_q <= 1'b1;
    end else if (s_resume) begin
      program_suspended_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      erase_suspended_flag_q <= 1'b0;
    end else if (s_sus_ers) begin
      erase_suspended_flag_q <= 1'b1;
    end else if (s_resume) begin
      erase_suspended_flag_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read parameters: persistent and working copies
  logic [7:0] rp_nv_q;
  logic [7:0] rp_q;
  logic rp_nv_wr;
  logic rp_wr;
  assign rp_nv_wr = cmd_is(cmd_go_q, code_q, frc_pkg::CMD_PARAMS_PERSISTENT);
  assign rp_wr = cmd_is(cmd_go_q, code_q, frc_pkg::CMD_PARAMS_WORKING_A)
                 || cmd_is(cmd_go_q, code_q, frc_pkg::CMD_PARAMS_WORKING_B);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rp_nv_q <= frc_pkg::PARAM_RESET;
    end else if (rp_nv_wr) begin
      rp_nv_q <= data_q;
    end
  end

  // working copy follows persistent copy until power-up ends
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rp_q <= frc_pkg::PARAM_RESET;
    end else if (!up_done_q) begin
      rp_q <= rp_nv_q;
    end else if (rp_wr) begin
      rp_q <= data_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // protection decode
  function automatic logic prot_hit(input logic [3:0] lvl, input logic bottom,
                                    input logic [BLOCK_W_P-1:0] blk);
    logic [BLOCK_W_P:0] cnt;
    logic [BLOCK_W_P-1:0] idx;
    cnt = '0;
    idx = bottom ? blk : (frc_pkg::BLOCK_LAST - blk);
    if (lvl >= 4'hA) begin
      cnt = 10'h200;
    end else if (lvl != 4'h0) begin
      cnt = 10'(10'h001 << (lvl - 4'h1));
    end
    prot_hit = {1'b0, idx} < cnt;
  endfunction : prot_hit

  //////////////////////////////////////////////////////////////////////////////
  // derived outputs
  logic [3:0] dummy_d;
  assign dummy_d = rp_q[frc_pkg::RP_DUMMY_HI:frc_pkg::RP_DUMMY_LO];
  always_ff @(posedge clk) begin
    if (!nrst) begin
      function_config_status <= 8'h00;
    end else begin
      function_config_status <= fn_word;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      read_parameters <= 8'h00;
    end else begin
      read_parameters <= rp_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      read_parameters_nv <= 8'h00;
    end else begin
      read_parameters_nv <= rp_nv_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_is_reset <= 1'b0;
    end else begin
      pin_is_reset <= !s_quad && !s_qpi && rst_dis_q
                      && rp_q[frc_pkg::RP_PIN_SEL];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dummy_cycles <= 4'h0;
    end else begin
      dummy_cycles <= (dummy_d == 4'h0) ? DEFAULT_DUMMY : dummy_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      burst_bytes <= 7'h00;
    end else begin
      burst_bytes <= 7'(7'h08 << rp_q[1:0]);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wrap_in_burst <= 1'b0;
    end else begin
      wrap_in_burst <= rp_q[frc_pkg::RP_WRAP];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      block_protected <= 1'b0;
    end else begin
      block_protected <= prot_hit(s_level, side_q, blk_s2_q);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      row_program_refused <= 1'b0;
    end else begin
      row_program_refused <= s_row_req && lock_q[s_row];
    end
  end
endmodule : frc_regs

// [frc_host.sv]
`timescale 1ns/100ps
module frc_host (
  input wire logic link_clk,
  output logic cmd_valid = 1'b0,
  output logic [7:0] cmd_code = 8'h00,
  output logic [7:0] cmd_data = 8'h00
);
  // one code and one data byte per strobe; released lines show inverse
  task send(input logic [7:0] c, input logic [7:0] v);
    @(posedge link_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_data <= v;
    @(posedge link_clk);
    cmd_valid <= 1'b0;
    cmd_code <= ~c;
    cmd_data <= ~v;
    @(posedge link_clk);
  endtask : send
endmodule : frc_host

// [frc_regs_checker.sv]
`timescale 1ns/100ps
module frc_chk #(
  parameter logic [3:0] DEFAULT_DUMMY = 4'h8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic suspend_pgm,
  input wire logic resume,
  input wire logic [3:0] protect_level,
  input wire logic [7:0] function_config_status,
  input wire logic [7:0] read_parameters,
  input wire logic [3:0] dummy_cycles,
  input wire logic [6:0] burst_bytes,
  input wire logic wrap_in_burst,
  input wire logic pin_is_reset,
  input wire logic block_protected,
  input wire logic row_program_refused
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_otp_sticky: assert property (
    ($past(function_config_status) & ~function_config_status & frc_pkg::FN_OTP_MASK) == 8'h00)
    else $error("one-time bit cleared");
  a_dummy_map: assert property ($past(nrst, 3) && $stable(read_parameters) |->
    dummy_cycles == (read_parameters[6:3] == 4'h0 ? DEFAULT_DUMMY : read_parameters[6:3]))
    else $error("dummy count wrong");
  a_burst_map: assert property ($past(nrst, 3) && $stable(read_parameters) |->
    burst_bytes == 7'h08 << read_parameters[1:0]) else $error("burst length wrong");
  a_wrap_bit: assert property ($past(nrst, 3) && $stable(read_parameters) |->
    wrap_in_burst == read_parameters[2]) else $error("wrap mode wrong");
  a_pin_reset_cause: assert property ($past(nrst, 3) && $stable(read_parameters)
    && $stable(function_config_status) && pin_is_reset |->
    function_config_status[0] && read_parameters[7]) else $error("pin reset without cause");
  a_pgm_susp_set: assert property ($rose(suspend_pgm) |->
    ##[2:8] function_config_status[2]) else $error("suspend flag not set");
  a_pgm_susp_clear: assert property ($rose(resume) |->
    ##[2:8] !function_config_status[2]) else $error("suspend flag not cleared");
  a_prot_none: assert property ((protect_level == 4'h0) [*6] |-> !block_protected)
    else $error("protected with level zero");
  a_prot_all: assert property ((protect_level[3:1] >= 3'h5) [*6] |-> block_protected)
    else $error("not protected at full level");
  a_row_free: assert property ((function_config_status[7:4] == 4'h0) [*7] |->
    !$past(row_program_refused)) else $error("row refused while unlocked");
endmodule : frc_chk

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  localparam logic [3:0] DD = 4'h8;
  logic clk = 0, nrst = 0, link_clk = 0, link_nrst = 0, cmd_valid, strap_rst_dis = 0;
  logic suspend_pgm = 0, suspend_ers = 0, resume = 0, row_program_req = 0;
  logic quad_lines_enable = 0, four_wire_command_mode = 0;
  logic [7:0] cmd_code, cmd_data, function_config_status, read_parameters, read_parameters_nv;
  logic [3:0] protect_level = 0, dummy_cycles;
  logic [frc_pkg::BLOCK_W-1:0] target_block = 0;
  logic [1:0] target_row = 0;
  logic [6:0] burst_bytes;
  logic pin_is_reset, wrap_in_burst, block_protected, row_program_refused;
  logic [7:0] f, r, n, d;
  logic [38:0] exq[$];
  int err_count = 0, tests_run = 0;
  event chk;
  frc_regs #(.DEFAULT_DUMMY(DD)) dut_u (
    .clk(clk), .nrst(nrst), .link_clk(link_clk), .link_nrst(link_nrst),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
    .strap_rst_dis(strap_rst_dis), .suspend_pgm(suspend_pgm), .suspend_ers(suspend_ers),
    .resume(resume), .quad_lines_enable(quad_lines_enable),
    .four_wire_command_mode(four_wire_command_mode), .protect_level(protect_level),
    .target_block(target_block), .target_row(target_row), .row_program_req(row_program_req),
    .function_config_status(function_config_status), .read_parameters(read_parameters),
    .read_parameters_nv(read_parameters_nv), .pin_is_reset(pin_is_reset),
    .dummy_cycles(dummy_cycles), .burst_bytes(burst_bytes), .wrap_in_burst(wrap_in_burst),
    .block_protected(block_protected), .row_program_refused(row_program_refused));
  frc_host host_u (.link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data));
  initial forever #12.5 clk = ~clk;
  initial begin
    #7;
    forever #62.5 link_clk = ~link_clk;
  end
  function automatic logic [38:0] ex(logic p, logic q);
    return {f, r, n, r[6:3] == 4'h0 ? DD : r[6:3], 7'h08 << r[1:0], r[2], p, q,
      !quad_lines_enable && !four_wire_command_mode && f[0] && r[7]};
  endfunction : ex
  task cmp(logic [38:0] s, logic [38:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("BAD outputs exp %h got %h", e, s);
    end
  endtask : cmp
  task ck(logic p, logic q);
    exq.push_back(ex(p, q));
    repeat (12) @(posedge clk);
    @(negedge clk);
    -> chk;
    @(posedge clk);
  endtask : ck
  always @(chk) cmp({function_config_status, read_parameters, read_parameters_nv, dummy_cycles,
    burst_bytes, wrap_in_burst, block_protected, row_program_refused, pin_is_reset},
    exq.pop_front());
  task stop_test;
    $display("checks %0d bad %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    stop_test;
  end
  initial begin
    f = 0;
    r = 0;
    n = 0;
    void'($urandom(44583));
    repeat (5) @(posedge clk);
    nrst <= 1;
    repeat (6) @(posedge clk);
    link_nrst <= 1;
    ck(0, 0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      d[1:0] = i[1:0];
      if (i == 1) d[6:3] = 4'h0;
      if (i == 3) d[7] = 1'b1;
      host_u.send(i == 0 ? frc_pkg::CMD_PARAMS_PERSISTENT : i == 2 ?
        frc_pkg::CMD_PARAMS_WORKING_B : frc_pkg::CMD_PARAMS_WORKING_A, d);
      if (i == 0) n = d;
      else r = d;
      ck(0, 0);
    end
    $display("test params done");
    host_u.send(frc_pkg::CMD_WRITE_FUNCTION, 8'hFF);
    f = 8'hF3;
    ck(0, 0);
    host_u.send(frc_pkg::CMD_WRITE_FUNCTION, 8'h00);
    ck(0, 0);
    $display("test function done");
    for (int i = 0; i < 2; i++) begin
      if (i == 0) suspend_pgm <= 1;
      else suspend_ers <= 1;
      f[2 + i] = 1'b1;
      ck(0, 0);
      suspend_pgm <= 0;
      suspend_ers <= 0;
      resume <= 1;
      repeat (4) @(posedge clk);
      resume <= 0;
      f[2 + i] = 1'b0;
      ck(0, 0);
    end
    $display("test suspend done");
    protect_level <= 4'h1;
    row_program_req <= 1;
    target_row <= 2'($urandom);
    quad_lines_enable <= 1;
    @(posedge clk);
    ck(1, 1);
    target_block <= frc_pkg::BLOCK_LAST;
    ck(0, 1);
    protect_level <= 4'hA;
    ck(1, 1);
    quad_lines_enable <= 0;
    four_wire_command_mode <= 1;
    @(posedge clk);
    ck(1, 1);
    four_wire_command_mode <= 0;
    @(posedge clk);
    ck(1, 1);
    $display("test protect done");
    host_u.send(frc_pkg::CMD_PARAMS_PERSISTENT, 8'hFF);
    n = 8'hFF;
    ck(1, 1);
    nrst <= 0;
    strap_rst_dis <= 1;
    protect_level <= 4'h1;
    repeat (5) @(posedge clk);
    nrst <= 1;
    f = 8'h01;
    r = 0;
    n = 0;
    ck(1, 0);
    $display("test strap done");
    stop_test;
  end
endmodule : tb_top
bind frc_regs frc_chk #(.DEFAULT_DUMMY(DEFAULT_DUMMY)) chk_u (
  .clk(clk), .nrst(nrst), .suspend_pgm(suspend_pgm), .resume(resume),
  .protect_level(protect_level), .function_config_status(function_config_status),
  .read_parameters(read_parameters), .dummy_cycles(dummy_cycles), .burst_bytes(burst_bytes),
  .wrap_in_burst(wrap_in_burst), .pin_is_reset(pin_is_reset),
  .block_protected(block_protected), .row_program_refused(row_program_refused));
